// ### sadc_top.sv
// Serial converter front end: frame control, sample hold and power mode.
// Assumes the host drives the bit clock and frame select; the core sample
// arrives as a digital word on the system clock.
`timescale 1ns/10ps
module sadc_top #(
   parameter int RES_BITS = sadc_pkg::RES_DEFAULT,
   parameter sadc_pkg::sadc_mode_e START_MODE = sadc_pkg::MODE_SHUT
) (
   input wire logic ref_clk, // System clock, 25 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic bitClk, // Host bit clock
   input wire logic frameSelN, // Frame select, active low
   input wire logic [RES_BITS-1:0] sampleIn, // Converted input level
   output logic serialResultOut, // Serial result data
   output logic serialResultOe, // Result pin enable, high drives
   output logic trackMode, // Input tracked, not held
   output logic modeNormal, // Normal mode, low in shutdown
   output logic fullPower, // Analog fully powered
   output logic dummyFrame, // Current frame is a wake dummy
   output logic quietViol // Frame started inside quiet gap
);

   // ****************************************
   // Declarations
   // ****************************************
   logic [3:0] syncQ;
   logic csSync;
   logic csPrevQ;
   logic csFall;
   logic csRise;
   logic [2:0] flagD1Q;
   logic [2:0] flagD2Q;
   logic doneSync;
   logic donePrevQ;
   logic doneRise;
   logic shutReq;
   sadc_pkg::sadc_mode_e modeQ;
   logic fullPowerQ;
   logic dummyQ;
   logic [RES_BITS-1:0] holdQ;
   logic holdRdyQ;
   logic releasedQ;
   logic [sadc_pkg::REL_W-1:0] relCntQ;
   logic quietViolQ;
   logic linkPast2;
   logic linkPast10;
   logic linkDone;

   // ****************************************
   // Crossing from the bit-clock side
   // ****************************************
   sadc_sync2 #(
      .W(4),
      .RST_VAL(4'h1)
   ) u_sync (
      .clk(ref_clk),
      .rst(srst),
      .d({linkDone, linkPast10, linkPast2, frameSelN}),
      .q(syncQ)
   );

   assign csSync = syncQ[0];
   assign doneSync = syncQ[3];

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         csPrevQ <= 1'b1;
         donePrevQ <= 1'b0;
      end else begin
         csPrevQ <= csSync;
         donePrevQ <= doneSync;
      end
   end

   assign csFall = csPrevQ & ~csSync;
   assign csRise = ~csPrevQ & csSync;
   assign doneRise = doneSync & ~donePrevQ;
   // Select rose after the 2nd but before the 10th falling edge
   assign shutReq = csRise & flagD2Q[0] & ~flagD2Q[1];

   // Flags clear together with the select rise; the delay line keeps the
   // values seen during the frame until the rise has been synchronised.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flagD1Q <= '0;
         flagD2Q <= '0;
      end else begin
         flagD1Q <= syncQ[3:1];
         flagD2Q <= flagD1Q;
      end
   end

   // ****************************************
   // Sample hold
   // ****************************************
   // capture word unchanged
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         holdQ <= '0;
      end else if (csFall) begin
         holdQ <= sampleIn;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         holdRdyQ <= 1'b0;
      end else if (csFall) begin
         holdRdyQ <= 1'b1;
      end else if (csRise) begin
         holdRdyQ <= 1'b0;
      end
   end

   // ****************************************
   // Power mode
   // ****************************************
   // start mode by parameter
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         modeQ <= START_MODE;
      end else if (csFall) begin
         modeQ <= sadc_pkg::MODE_NORM;
      end else if (shutReq) begin
         modeQ <= sadc_pkg::MODE_SHUT;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fullPowerQ <= 1'b0;
      end else if (modeQ == sadc_pkg::MODE_SHUT || shutReq) begin
         fullPowerQ <= 1'b0;
      end else if (doneRise) begin
         fullPowerQ <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dummyQ <= 1'b0;
      end else if (csFall) begin
         dummyQ <= ~fullPowerQ | (modeQ == sadc_pkg::MODE_SHUT);
      end
   end

   // ****************************************
   // Quiet gap watch
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         releasedQ <= 1'b1;
      end else if (csFall) begin
         releasedQ <= 1'b0;
      end else if (csRise || doneRise) begin
         releasedQ <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         relCntQ <= '1;
      end else if (csFall || !releasedQ) begin
         relCntQ <= '0;
      end else if (relCntQ != '1) begin
         relCntQ <= relCntQ + 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         quietViolQ <= 1'b0;
      end else begin
         quietViolQ <= csFall && (relCntQ < sadc_pkg::REL_W'(sadc_pkg::QUIET_CYC));
      end
   end

   // ****************************************
   // Bit-clock side
   // ****************************************
   sadc_link #(
      .RES(RES_BITS)
   ) u_link (
      .bitClk(bitClk),
      .frameSelN(frameSelN),
      .holdWord(holdQ),
      .holdRdy(holdRdyQ),
      .dataOut(serialResultOut),
      .dataOe(serialResultOe),
      .trackMode(trackMode),
      .past2Q(linkPast2),
      .past10Q(linkPast10),
      .doneQ(linkDone)
   );

   assign modeNormal = (modeQ == sadc_pkg::MODE_NORM);
   assign fullPower = fullPowerQ;
   assign dummyFrame = dummyQ;
   assign quietViol = quietViolQ;

   // ****************************************
   // Checks
   // ****************************************
   a_hold_capture: assert property (@(posedge ref_clk) disable iff (srst)
      csFall |=> holdQ == $past(sampleIn))
      else $error("sample not captured at frame start");

   a_hold_stable: assert property (@(posedge ref_clk) disable iff (srst)
      holdRdyQ && !csFall |=> $stable(holdQ))
      else $error("held sample changed inside frame");

   a_frame_ready: assert property (@(posedge ref_clk) disable iff (srst)
      csFall |=> holdRdyQ ##1 holdRdyQ)
      else $error("frame start did not enable the result");

   a_wake_normal: assert property (@(posedge ref_clk) disable iff (srst)
      csFall |=> modeNormal)
      else $error("select low did not give normal mode");

   a_shut_sticks: assert property (@(posedge ref_clk) disable iff (srst)
      !modeNormal && !csFall |=> !modeNormal)
      else $error("left shutdown without select low");

   a_shut_entry: assert property (@(posedge ref_clk) disable iff (srst)
      csRise && flagD2Q[0] && !flagD2Q[1] |=> !modeNormal && !fullPower)
      else $error("early rise did not shut down");

   a_glitch_keep: assert property (@(posedge ref_clk) disable iff (srst)
      csRise && !flagD2Q[0] |=> modeNormal == $past(modeNormal))
      else $error("glitch on select changed mode");

   a_late_keep: assert property (@(posedge ref_clk) disable iff (srst)
      csRise && flagD2Q[1] |=> modeNormal)
      else $error("late rise left normal mode");

   a_powered_16: assert property (@(posedge ref_clk) disable iff (srst)
      doneRise && modeNormal |=> fullPower)
      else $error("not powered after sixteen clocks");

   a_quiet_flag: assert property (@(posedge ref_clk) disable iff (srst)
      csFall && relCntQ == '0 |=> quietViol ##1 !quietViol)
      else $error("quiet gap breach not flagged");

   a_release_done: assert property (@(posedge ref_clk) disable iff (srst)
      doneSync |-> !serialResultOe)
      else $error("result pin driven after last bit");

endmodule // sadc_top

// ### sadc_pkg.sv
// Constants, mode codes and frame layout of the serial converter front end.
// Assumes a 25 MHz system clock and a host-driven bit clock on its own domain.
package sadc_pkg;

   // ****************************************
   // Frame layout
   // ****************************************
   localparam int RES_DEFAULT = 12;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] LEAD_ZEROS = 5'h04;
   localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
   localparam logic [CNT_W-1:0] TRACK_EDGE = 5'h0D;
   localparam logic [CNT_W-1:0] SHUT_EDGE = 5'h02;
   localparam logic [CNT_W-1:0] NORM_EDGE = 5'h0A;

   // ****************************************
   // Timing
   // ****************************************
   localparam int REF_PERIOD_NS = 40;
   localparam int QUIET_NS = 50;
   localparam int QUIET_CYC = (QUIET_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int REL_W = 4;

   // ****************************************
   // Power modes
   // ****************************************
   typedef enum logic [1:0] {
      MODE_SHUT = 2'b01,
      MODE_NORM = 2'b10
   } sadc_mode_e;

endpackage

// ### sadc_sync2.sv
// Two-stage synchroniser for a group of independent level signals.
// Assumes each bit is a level that stays put for several destination cycles.
`timescale 1ns/10ps
module sadc_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk, // Destination clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic [W-1:0] d, // Levels from the other domain
   output logic [W-1:0] q // Synchronised levels
);

   logic [W-1:0] metaQ;

   always_ff @(posedge clk) begin
      if (rst) begin
         metaQ <= RST_VAL;
         q <= RST_VAL;
      end else begin
         metaQ <= d;
         q <= metaQ;
      end
   end

endmodule // sadc_sync2

// ### sadc_link.sv
// Bit-clock side of the frame: counts edges, shifts the result out.
// Assumes the frame select clears this logic asynchronously while high.
`timescale 1ns/10ps
module sadc_link #(
   parameter int RES = 12
) (
   input wire logic bitClk, // Host bit clock
   input wire logic frameSelN, // Frame select, active low
   input wire logic [RES-1:0] holdWord, // Held sample, stable in frame
   input wire logic holdRdy, // Held sample valid level
   output logic dataOut, // Serial result bit
   output logic dataOe, // Output enable of result pin
   output logic trackMode, // High while input is tracked
   output logic past2Q, // Second falling edge seen
   output logic past10Q, // Tenth falling edge seen
   output logic doneQ // Sixteenth falling edge seen
);

   logic [sadc_pkg::CNT_W-1:0] fallCntQ;
   logic [sadc_pkg::CNT_W-1:0] fallCntD;
   logic [sadc_pkg::CNT_W-1:0] riseCntQ;
   logic rdyMetaQ;
   logic rdyQ;

   function automatic logic frameBit(input logic [sadc_pkg::CNT_W-1:0] idx);
      int pos;
      pos = RES + int'(sadc_pkg::LEAD_ZEROS) - int'(idx);
      frameBit = 1'b0;
      if (idx > sadc_pkg::LEAD_ZEROS && pos >= 0) begin
         frameBit = holdWord[pos];
      end
   endfunction

   assign fallCntD = (fallCntQ == sadc_pkg::FRAME_BITS) ? fallCntQ : fallCntQ + 5'h01;

   always_ff @(negedge bitClk or posedge frameSelN) begin
      if (frameSelN) begin
         fallCntQ <= '0;
         past2Q <= 1'b0;
         past10Q <= 1'b0;
         doneQ <= 1'b0;
      end else begin
         fallCntQ <= fallCntD;
         past2Q <= past2Q | (fallCntD >= sadc_pkg::SHUT_EDGE);
         past10Q <= past10Q | (fallCntD >= sadc_pkg::NORM_EDGE);
         doneQ <= doneQ | (fallCntD == sadc_pkg::FRAME_BITS);
      end
   end

   always_ff @(negedge bitClk or posedge frameSelN) begin
      if (frameSelN) begin
         rdyMetaQ <= 1'b0;
         rdyQ <= 1'b0;
      end else begin
         rdyMetaQ <= holdRdy;
         rdyQ <= rdyMetaQ;
      end
   end

   always_ff @(negedge bitClk or posedge frameSelN) begin
      if (frameSelN) begin
         dataOut <= 1'b0;
      end else begin
         dataOut <= rdyQ & frameBit(sadc_pkg::CNT_W'(fallCntD + 5'h01));
      end
   end

   always_ff @(posedge bitClk or posedge frameSelN) begin
      if (frameSelN) begin
         riseCntQ <= '0;
      end else if (riseCntQ != sadc_pkg::TRACK_EDGE) begin
         riseCntQ <= riseCntQ + 5'h01;
      end
   end

   assign trackMode = frameSelN | (riseCntQ == sadc_pkg::TRACK_EDGE);
   assign dataOe = ~frameSelN & ~doneQ;

   // ****************************************
   // Checks
   // ****************************************
   a_lead_zeros: assert property (@(negedge bitClk) disable iff (frameSelN)
      fallCntQ < sadc_pkg::LEAD_ZEROS |-> !dataOut)
      else $error("leading zero missing");

   a_release_16: assert property (@(negedge bitClk) disable iff (frameSelN)
      fallCntQ < sadc_pkg::FRAME_BITS |-> dataOe)
      else $error("output released before last bit");

   a_lsb_last: assert property (@(negedge bitClk) disable iff (frameSelN)
      fallCntQ == sadc_pkg::FRAME_BITS - 5'h01 && rdyQ && RES == 12 |-> dataOut == holdWord[0])
      else $error("lsb not on last falling edge");

   a_track_13: assert property (@(posedge bitClk) disable iff (frameSelN)
      riseCntQ == sadc_pkg::TRACK_EDGE - 5'h01 |=> trackMode)
      else $error("not tracking after 13th rising edge");

endmodule // sadc_link

// ### sadc_host_model.sv
// Host serial port model: frame select and a bit clock that runs only in frames.
// Assumes the bench calls run_frame with the bit clock standing low.
`timescale 1ns/10ps
module sadc_host_model (
   output logic bitClk, // Host bit clock, 80 ns period in frames
   output logic frameSelN, // Frame select, active low
   input wire logic serialResultOut, // Serial result data
   input wire logic serialResultOe, // Result pin enable
   input wire logic trackMode, // Input tracked
   input wire logic modeNormal, // Normal mode
   input wire logic dummyFrame // Wake dummy frame
);
   logic lastQ = 1'b0;
   wire pinLevel;
   // Released pin shows the inverse of its last driven level
   assign pinLevel = serialResultOe ? serialResultOut : ~lastQ;
   always @(negedge bitClk) begin
      if (serialResultOe) begin
         lastQ <= serialResultOut;
      end
   end
   // A low then high select clears the link side, which has no reset
   initial begin
      bitClk = 1'b0;
      frameSelN = 1'b0;
      #5 frameSelN = 1'b1;
   end
   // ****************************************
   // One frame of nFalls falling edges
   // ****************************************
   task automatic run_frame(input int nFalls, output logic [15:0] bits,
      output logic [15:0] trk, output logic [15:0] oe, output logic [2:0] mid,
      output logic oeEnd);
      bits = '0;
      trk = '0;
      oe = '0;
      mid = '0;
      #13;
      frameSelN = 1'b0;
      // clock starts with a rising edge
      for (int k = 1; k <= nFalls; k++) begin
         #40 bitClk = 1'b1;
         #39;
         // bit taken just before the next falling edge
         bits[16-k] = pinLevel;
         trk[16-k] = trackMode;
         oe[16-k] = serialResultOe;
         if (k == 8) begin
            mid = {dummyFrame, modeNormal, 1'b1};
         end
         #1 bitClk = 1'b0;
      end
      #100 oeEnd = serialResultOe;
      frameSelN = 1'b1;
      // select raised and quiet gap kept
      #400;
   endtask
endmodule // sadc_host_model

// ### tb.sv
// Bench for the serial converter front end, 12-bit build.
// Assumes the host model paces the link; the sample word is set on ref_clk.
`timescale 1ns/10ps
module tb;
   localparam int RES = 12;
   logic ref_clk;
   logic srst;
   logic bitClk;
   logic frameSelN;
   logic [RES-1:0] sampleIn;
   logic serialResultOut;
   logic serialResultOe;
   logic trackMode;
   logic modeNormal;
   logic fullPower;
   logic dummyFrame;
   logic quietViol;
   int mismatches;
   int num_checks;
   int cycles;
   int quietCount;
   logic [15:0] bits;
   logic [15:0] trk;
   logic [15:0] oe;
   logic [2:0] mid;
   logic oeEnd;
   sadc_top #(.RES_BITS(RES), .START_MODE(sadc_pkg::MODE_SHUT)) sadc_top_i (
      .ref_clk(ref_clk), .srst(srst), .bitClk(bitClk), .frameSelN(frameSelN),
      .sampleIn(sampleIn), .serialResultOut(serialResultOut),
      .serialResultOe(serialResultOe), .trackMode(trackMode), .modeNormal(modeNormal),
      .fullPower(fullPower), .dummyFrame(dummyFrame), .quietViol(quietViol));
   sadc_host_model sadc_host_model_i (
      .bitClk(bitClk), .frameSelN(frameSelN), .serialResultOut(serialResultOut),
      .serialResultOe(serialResultOe), .trackMode(trackMode), .modeNormal(modeNormal),
      .dummyFrame(dummyFrame));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Cycle ceiling and quiet gap monitor
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (quietViol !== 1'b0 && srst === 1'b0) begin
         quietCount = quietCount + 1;
      end
      if (cycles == 2000) begin
         mismatches = mismatches + 1;
         complete_run();
      end
   end
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic frame(input int n, input logic [RES-1:0] s);
      @(posedge ref_clk);
      sampleIn <= s;
      @(posedge ref_clk);
      sadc_host_model_i.run_frame(n, bits, trk, oe, mid, oeEnd);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      check("mode", 16'h0000, {15'h0000, modeNormal});
      check("power", 16'h0000, {15'h0000, fullPower});
      check("idle", 16'h0002, {14'h0000, trackMode, serialResultOe});
   endtask
   task automatic t_wake(input logic [RES-1:0] s);
      frame(16, s);
      check("word", {4'h0, s}, bits);
      check("track", 16'h000F, trk);
      check("oe", 16'hFFFF, oe);
      check("oeEnd", 16'h0000, {15'h0000, oeEnd});
      check("mid", 16'h0007, {13'h0000, mid});
      check("power", 16'h0001, {15'h0000, fullPower});
   endtask
   task automatic t_normal();
      frame(16, 12'hFFF);
      check("word", 16'h0FFF, bits);
      check("mid", 16'h0003, {13'h0000, mid});
      frame(16, 12'h001);
      check("word", 16'h0001, bits);
   endtask
   task automatic t_glitch();
      frame(1, 12'h555);
      check("mode", 16'h0001, {15'h0000, modeNormal});
      check("oe", 16'h0000, {15'h0000, serialResultOe});
   endtask
   task automatic t_trunc();
      frame(10, 12'h3C7);
      check("word", 16'h03C7 & 16'hFFC0, bits);
      check("oeEnd", 16'h0001, {15'h0000, oeEnd});
      check("oe", 16'h0000, {15'h0000, serialResultOe});
      check("mode", 16'h0001, {15'h0000, modeNormal});
   endtask
   task automatic t_shut();
      frame(2, 12'hABC);
      check("mode", 16'h0000, {15'h0000, modeNormal});
      check("power", 16'h0000, {15'h0000, fullPower});
      check("oe", 16'h0000, {15'h0000, serialResultOe});
   endtask
   initial begin
      mismatches = 0;
      num_checks = 0;
      cycles = 0;
      quietCount = 0;
      srst = 1'b1;
      sampleIn = '0;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_wake(12'hA5C);
      t_normal();
      t_glitch();
      t_trunc();
      t_shut();
      t_wake(12'h6E1);
      check("quiet", 16'h0000, quietCount[15:0]);
      complete_run();
   end
endmodule // tb
